/* File: rtl/eais_pkg.sv */
package eais_pkg;

	// ************************************************************
	// Widths
	// ************************************************************
	localparam int SAMPLE_W   = 16;
	localparam int VOLT_W     = 17;
	localparam int POWER_W    = 33;
	localparam int APPARENT_W = 32;
	localparam int ENERGY_W   = 48;
	localparam int ADDR_W     = 8;
	localparam int NUM_PHASES = 3;
	localparam int PHASE_B    = 1;

	// ************************************************************
	// Register offsets
	// ************************************************************
	localparam logic [7:0] OFS_ACCUM_MODE_CFG = 8'h00;
	localparam logic [7:0] OFS_SAG_LEVEL      = 8'h04;
	localparam logic [7:0] OFS_STATUS         = 8'h08;
	localparam logic [7:0] OFS_BV_RMS         = 8'h0C;

	// ************************************************************
	// Field positions and reset values
	// ************************************************************
	localparam int VAR_LSB       = 2;
	localparam int TOPO_LSB      = 4;
	localparam int SAG_MODE_BIT  = 6;
	localparam int SAG_FLAG_BIT  = 0;
	localparam logic [7:0]  ACCUM_MODE_RESET = 8'h80;
	localparam logic [7:0]  RSV_MASK         = 8'h80;
	localparam logic [15:0] SAG_LEVEL_RESET  = 16'h0000;

	// ************************************************************
	// Mode codes
	// ************************************************************
	localparam logic [1:0] VAR_SIGNED     = 2'h0;
	localparam logic [1:0] VAR_SIGNED_ALT = 2'h1;
	localparam logic [1:0] VAR_BY_ACTIVE  = 2'h2;
	localparam logic [1:0] VAR_ABS        = 2'h3;
	localparam logic [1:0] TOPO_4W_WYE    = 2'h0;
	localparam logic [1:0] TOPO_3W_DELTA  = 2'h1;
	localparam logic [1:0] TOPO_RSVD      = 2'h2;
	localparam logic [1:0] TOPO_4W_DELTA  = 2'h3;

	typedef enum logic
	{
		SAG_ABOVE = 1'b0,
		SAG_BELOW = 1'b1
	} eais_sag_state_e;

endpackage : eais_pkg

/* File: rtl/eais_phase_power.sv */
module eais_phase_power
(
	// Clock and reset
	input  logic                                clk,
	input  logic                                rst,
	// Control
	input  logic                                upd,
	input  logic [1:0]                          var_mode,
	// Phase inputs
	input  logic signed [eais_pkg::VOLT_W-1:0]   v,
	input  logic signed [eais_pkg::SAMPLE_W-1:0] i,
	input  logic signed [eais_pkg::SAMPLE_W-1:0] i_q,
	input  logic [eais_pkg::SAMPLE_W-1:0]        v_rms,
	input  logic [eais_pkg::SAMPLE_W-1:0]        i_rms,
	// Results
	output logic signed [eais_pkg::POWER_W-1:0]  active_pwr,
	output logic signed [eais_pkg::POWER_W-1:0]  reactive_pwr,
	output logic [eais_pkg::APPARENT_W-1:0]      apparent_pwr,
	output logic signed [eais_pkg::ENERGY_W-1:0] active_nrg,
	output logic signed [eais_pkg::ENERGY_W-1:0] reactive_nrg,
	output logic [eais_pkg::ENERGY_W-1:0]        apparent_nrg
);
	localparam int EXT_W = eais_pkg::ENERGY_W - eais_pkg::POWER_W;
	logic signed [eais_pkg::POWER_W-1:0]  p, q_raw, q_adj;
	logic [eais_pkg::APPARENT_W-1:0]      s;
	logic signed [eais_pkg::POWER_W-1:0]  p_reg, q_reg;
	logic [eais_pkg::APPARENT_W-1:0]      s_reg;
	logic signed [eais_pkg::ENERGY_W-1:0] pe_reg, pe_next, qe_reg, qe_next;
	logic [eais_pkg::ENERGY_W-1:0]        se_reg, se_next;

	always_comb
	begin
		p = v * i;
		q_raw = v * i_q;
		s = v_rms * i_rms;
		case (var_mode)
			eais_pkg::VAR_BY_ACTIVE: q_adj = p[eais_pkg::POWER_W-1] ? -q_raw : q_raw;
			eais_pkg::VAR_ABS: q_adj = q_raw[eais_pkg::POWER_W-1] ? -q_raw : q_raw;
			default: q_adj = q_raw;
		endcase
		pe_next = pe_reg;
		qe_next = qe_reg;
		se_next = se_reg;
		if (upd)
		begin
			pe_next = pe_reg + {{EXT_W{p[eais_pkg::POWER_W-1]}}, p};
			qe_next = qe_reg + {{EXT_W{q_adj[eais_pkg::POWER_W-1]}}, q_adj};
			se_next = se_reg + {{(eais_pkg::ENERGY_W-eais_pkg::APPARENT_W){1'b0}}, s};
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			p_reg <= '0;
			q_reg <= '0;
			s_reg <= '0;
			pe_reg <= '0;
			qe_reg <= '0;
			se_reg <= '0;
		end
		else
		begin
			if (upd)
			begin
				p_reg <= p;
				q_reg <= q_adj;
				s_reg <= s;
			end
			pe_reg <= pe_next;
			qe_reg <= qe_next;
			se_reg <= se_next;
		end
	end

	assign active_pwr = p_reg;
	assign reactive_pwr = q_reg;
	assign apparent_pwr = s_reg;
	assign active_nrg = pe_reg;
	assign reactive_nrg = qe_reg;
	assign apparent_nrg = se_reg;

	default clocking cb_ph @(posedge clk); endclocking
	default disable iff (rst);

	a_react_by_sign: assert property (upd && var_mode == eais_pkg::VAR_BY_ACTIVE |=>
		reactive_pwr == ($past(p) < 0 ? -$past(q_raw) : $past(q_raw)))
		else $error("reactive sign does not follow active sign");
	a_react_abs_pos: assert property (upd && var_mode == eais_pkg::VAR_ABS |=>
		!reactive_pwr[eais_pkg::POWER_W-1] && reactive_nrg >= $past(reactive_nrg))
		else $error("absolute reactive mode produced a negative step");
	a_react_alt_code: assert property (upd && var_mode == eais_pkg::VAR_SIGNED_ALT |=>
		reactive_pwr == $past(q_raw))
		else $error("reactive code 01 differs from signed mode");
	a_energy_hold: assert property (!upd |=> $stable(active_nrg) && $stable(apparent_nrg))
		else $error("energy moved without an update");

endmodule : eais_phase_power

/* File: rtl/eais_sag_detect.sv */
module eais_sag_detect
(
	// Clock and reset
	input  logic                                clk,
	input  logic                                rst,
	// Control
	input  logic                                upd,
	input  logic                                rise_mode,
	input  logic                                clr,
	input  logic [eais_pkg::SAMPLE_W-1:0]        level,
	// Voltages
	input  logic signed [eais_pkg::SAMPLE_W-1:0] v_ph [eais_pkg::NUM_PHASES],
	// Flag
	output logic                                sag_flag
);
	eais_pkg::eais_sag_state_e st_reg [eais_pkg::NUM_PHASES];
	eais_pkg::eais_sag_state_e st_next [eais_pkg::NUM_PHASES];
	logic [eais_pkg::NUM_PHASES-1:0] below, rose;
	logic [eais_pkg::SAMPLE_W:0] mag;
	logic flag_reg, flag_next, set_ev;

	always_comb
	begin
		mag = '0;
		for (int k = 0; k < eais_pkg::NUM_PHASES; k++)
		begin
			mag = v_ph[k][eais_pkg::SAMPLE_W-1] ? -{v_ph[k][eais_pkg::SAMPLE_W-1], v_ph[k]}
				: {1'b0, v_ph[k]};
			below[k] = mag < {1'b0, level};
			rose[k] = (st_reg[k] == eais_pkg::SAG_BELOW) && !below[k];
			st_next[k] = st_reg[k];
			if (upd)
			begin
				case (st_reg[k])
					eais_pkg::SAG_ABOVE: if (below[k]) st_next[k] = eais_pkg::SAG_BELOW;
					eais_pkg::SAG_BELOW: if (!below[k]) st_next[k] = eais_pkg::SAG_ABOVE;
					default: st_next[k] = eais_pkg::SAG_ABOVE;
				endcase
			end
		end
		set_ev = upd && (rise_mode ? |rose : |below);
		// Set wins over a clear in the same cycle.
		flag_next = set_ev | (flag_reg & ~clr);
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			flag_reg <= 1'b0;
			for (int k = 0; k < eais_pkg::NUM_PHASES; k++)
				st_reg[k] <= eais_pkg::SAG_ABOVE;
		end
		else
		begin
			flag_reg <= flag_next;
			st_reg <= st_next;
		end
	end

	assign sag_flag = flag_reg;

	default clocking cb_sag @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_recovered;
		upd && rise_mode && |rose;
	endsequence
	a_sag_level_set: assert property (upd && !rise_mode && |below |=> sag_flag)
		else $error("sag flag missed a low voltage");
	a_sag_rise_set: assert property (s_recovered |=> sag_flag)
		else $error("sag flag missed a recovery");
	a_sag_no_early: assert property (upd && rise_mode && !(|rose) && !sag_flag |=> !sag_flag)
		else $error("sag flag set before recovery");
	a_sag_clear: assert property (clr && !set_ev |=> !sag_flag)
		else $error("sag flag not cleared");

endmodule : eais_sag_detect

/* File: rtl/eais_energy_accum_input_select.sv */
// Function
// - Reactive mode code 01 behaves exactly like code 00, signed accumulation.
// - Code 10 keeps reactive sign for positive active power, inverts for negative.
// - Code 11 accumulates reactive magnitude, same for energy and reactive power output.
// - Bits 5:4 choose topology: wye, three-wire delta, reserved, four-wire delta.
// - Each phase forms v*i, v*i_quarter and vrms*irms products.
// - Three-wire uses phase A minus phase C voltage as phase B voltage.
// - Three-wire stores line voltage A-C rms in phase B voltage rms register.
// - Three-wire forces filtered phase B current to zero, zeroing phase B powers.
// - Bit 6, reset 0, picks how the sag status flag is produced.
// - Bit 6 clear: flag set when any phase voltage is below threshold.
// - Bit 6 set: flag set after a phase dips below then recovers.
// - Bit 7 is reserved, reads one, and steers nothing.
//
// Implementation choices: the address map and the Wishbone interface to the registers.
module eais_energy_accum_input_select
(
	// Clock and reset
	input  logic                                clk,
	input  logic                                rst,
	// Wishbone slave
	input  logic                                wb_cyc_i,
	input  logic                                wb_stb_i,
	input  logic                                wb_we_i,
	input  logic [eais_pkg::ADDR_W-1:0]          wb_adr_i,
	input  logic [3:0]                          wb_sel_i,
	input  logic [31:0]                         wb_dat_i,
	output logic [31:0]                         wb_dat_o,
	output logic                                wb_ack_o,
	// Accumulator update strobe
	input  logic                                sample_upd,
	// Instantaneous voltages
	input  logic signed [eais_pkg::SAMPLE_W-1:0] va_smp,
	input  logic signed [eais_pkg::SAMPLE_W-1:0] vb_smp,
	input  logic signed [eais_pkg::SAMPLE_W-1:0] vc_smp,
	// Filtered currents
	input  logic signed [eais_pkg::SAMPLE_W-1:0] ia_smp,
	input  logic signed [eais_pkg::SAMPLE_W-1:0] ib_smp,
	input  logic signed [eais_pkg::SAMPLE_W-1:0] ic_smp,
	// Quarter-cycle delayed currents
	input  logic signed [eais_pkg::SAMPLE_W-1:0] ia_q_smp,
	input  logic signed [eais_pkg::SAMPLE_W-1:0] ib_q_smp,
	input  logic signed [eais_pkg::SAMPLE_W-1:0] ic_q_smp,
	// Rms values
	input  logic [eais_pkg::SAMPLE_W-1:0]        va_rms,
	input  logic [eais_pkg::SAMPLE_W-1:0]        vb_rms,
	input  logic [eais_pkg::SAMPLE_W-1:0]        vc_rms,
	input  logic [eais_pkg::SAMPLE_W-1:0]        vac_rms,
	input  logic [eais_pkg::SAMPLE_W-1:0]        ia_rms,
	input  logic [eais_pkg::SAMPLE_W-1:0]        ib_rms,
	input  logic [eais_pkg::SAMPLE_W-1:0]        ic_rms,
	// Feeds toward the rms engine
	output logic signed [eais_pkg::VOLT_W-1:0]   line_vac_smp,
	output logic signed [eais_pkg::SAMPLE_W-1:0] ib_filt_out,
	// Per-phase powers, index 0 is phase A
	output logic [2:0][eais_pkg::POWER_W-1:0]    active_pwr,
	output logic [2:0][eais_pkg::POWER_W-1:0]    reactive_pwr,
	output logic [2:0][eais_pkg::APPARENT_W-1:0] apparent_pwr,
	// Per-phase energies
	output logic [2:0][eais_pkg::ENERGY_W-1:0]   active_nrg,
	output logic [2:0][eais_pkg::ENERGY_W-1:0]   reactive_nrg,
	output logic [2:0][eais_pkg::ENERGY_W-1:0]   apparent_nrg,
	// Status
	output logic                                sag_flag_out
);

	// ************************************************************
	// Register bus
	// ************************************************************
	logic [7:0]  cfg_reg, cfg_next;
	logic [15:0] level_reg, level_next;
	logic [15:0] phase_b_voltage_rms_reg, phase_b_voltage_rms_next;
	logic [31:0] rdat_reg, rdat_next;
	logic        ack_reg, ack_next;
	logic        bus_req, wr_fire, rd_fire, sag_clr, sag_flag;

	// Ack is registered, so every request sees one wait state and a held
	// request is answered only every other cycle.

	// Only the word part of the address is compared.
	function automatic logic reg_hit(input logic [7:0] adr, input logic [7:0] ofs);
		reg_hit = (adr[7:2] == ofs[7:2]);
	endfunction : reg_hit

	always_comb
	begin
		bus_req = wb_cyc_i & wb_stb_i;
		ack_next = bus_req & ~ack_reg;
		wr_fire = bus_req & wb_we_i & ~ack_reg;
		rd_fire = bus_req & ~wb_we_i & ~ack_reg;
		cfg_next = cfg_reg;
		level_next = level_reg;
		rdat_next = rdat_reg;
		sag_clr = 1'b0;
		if (wr_fire && reg_hit(wb_adr_i, eais_pkg::OFS_ACCUM_MODE_CFG) && wb_sel_i[0])
		begin
			cfg_next = wb_dat_i[7:0] | eais_pkg::RSV_MASK;
		end
		if (wr_fire && reg_hit(wb_adr_i, eais_pkg::OFS_SAG_LEVEL))
		begin
			if (wb_sel_i[0])
				level_next[7:0] = wb_dat_i[7:0];
			if (wb_sel_i[1])
				level_next[15:8] = wb_dat_i[15:8];
		end
		if (wr_fire && reg_hit(wb_adr_i, eais_pkg::OFS_STATUS) && wb_sel_i[0])
			sag_clr = wb_dat_i[eais_pkg::SAG_FLAG_BIT];
		if (rd_fire)
		begin
			rdat_next = 32'h00000000;
			if (reg_hit(wb_adr_i, eais_pkg::OFS_ACCUM_MODE_CFG))
				rdat_next[7:0] = cfg_reg;
			else if (reg_hit(wb_adr_i, eais_pkg::OFS_SAG_LEVEL))
				rdat_next[15:0] = level_reg;
			else if (reg_hit(wb_adr_i, eais_pkg::OFS_STATUS))
				rdat_next[eais_pkg::SAG_FLAG_BIT] = sag_flag;
			else if (reg_hit(wb_adr_i, eais_pkg::OFS_BV_RMS))
				rdat_next[15:0] = phase_b_voltage_rms_reg;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			cfg_reg <= eais_pkg::ACCUM_MODE_RESET;
			level_reg <= eais_pkg::SAG_LEVEL_RESET;
			rdat_reg <= 32'h00000000;
			ack_reg <= 1'b0;
		end
		else
		begin
			cfg_reg <= cfg_next;
			level_reg <= level_next;
			rdat_reg <= rdat_next;
			ack_reg <= ack_next;
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdat_reg;

	// ************************************************************
	// Topology selection
	// ************************************************************
	logic [1:0] topo, var_mode;
	logic signed [eais_pkg::VOLT_W-1:0]   va_ext, vc_ext, vb_eff, vac_next, vac_reg;
	logic signed [eais_pkg::SAMPLE_W-1:0] ib_eff, ibq_eff, ibf_reg;
	logic [eais_pkg::SAMPLE_W-1:0]        vbrms_eff, ibrms_eff;

	always_comb
	begin
		topo = cfg_reg[eais_pkg::TOPO_LSB +: 2];
		var_mode = cfg_reg[eais_pkg::VAR_LSB +: 2];
		va_ext = {va_smp[eais_pkg::SAMPLE_W-1], va_smp};
		vc_ext = {vc_smp[eais_pkg::SAMPLE_W-1], vc_smp};
		vac_next = va_ext - vc_ext;
		vb_eff = {vb_smp[eais_pkg::SAMPLE_W-1], vb_smp};
		ib_eff = ib_smp;
		ibq_eff = ib_q_smp;
		vbrms_eff = vb_rms;
		ibrms_eff = ib_rms;
		case (topo)
			eais_pkg::TOPO_3W_DELTA:
			begin
				vb_eff = vac_next;
				ib_eff = '0;
				ibq_eff = '0;
				ibrms_eff = '0;
				vbrms_eff = vac_rms;
			end
			eais_pkg::TOPO_4W_DELTA:
			begin
				vb_eff = -va_ext;
				vbrms_eff = va_rms;
			end
			// Reserved code 10 falls back to the wye wiring, harmless if written.
			default:
			begin
				vb_eff = {vb_smp[eais_pkg::SAMPLE_W-1], vb_smp};
			end
		endcase
		phase_b_voltage_rms_next = vbrms_eff;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			vac_reg <= '0;
			ibf_reg <= '0;
			phase_b_voltage_rms_reg <= '0;
		end
		else
		begin
			vac_reg <= vac_next;
			ibf_reg <= ib_eff;
			phase_b_voltage_rms_reg <= phase_b_voltage_rms_next;
		end
	end

	assign line_vac_smp = vac_reg;
	assign ib_filt_out = ibf_reg;

	// ************************************************************
	// Phase engines
	// ************************************************************
	logic signed [eais_pkg::VOLT_W-1:0]   v_ph  [eais_pkg::NUM_PHASES];
	logic signed [eais_pkg::SAMPLE_W-1:0] i_ph  [eais_pkg::NUM_PHASES];
	logic signed [eais_pkg::SAMPLE_W-1:0] iq_ph [eais_pkg::NUM_PHASES];
	logic signed [eais_pkg::SAMPLE_W-1:0] vs_ph [eais_pkg::NUM_PHASES];
	logic [eais_pkg::SAMPLE_W-1:0]        vr_ph [eais_pkg::NUM_PHASES];
	logic [eais_pkg::SAMPLE_W-1:0]        ir_ph [eais_pkg::NUM_PHASES];

	always_comb
	begin
		v_ph[0] = va_ext;
		v_ph[1] = vb_eff;
		v_ph[2] = vc_ext;
		i_ph[0] = ia_smp;
		i_ph[1] = ib_eff;
		i_ph[2] = ic_smp;
		iq_ph[0] = ia_q_smp;
		iq_ph[1] = ibq_eff;
		iq_ph[2] = ic_q_smp;
		vr_ph[0] = va_rms;
		vr_ph[1] = vbrms_eff;
		vr_ph[2] = vc_rms;
		ir_ph[0] = ia_rms;
		ir_ph[1] = ibrms_eff;
		ir_ph[2] = ic_rms;
		vs_ph[0] = va_smp;
		vs_ph[1] = vb_smp;
		vs_ph[2] = vc_smp;
	end

	genvar g;
	generate
		for (g = 0; g < eais_pkg::NUM_PHASES; g++)
		begin : g_phase
			eais_phase_power u_phase
			(
				.clk          (clk),
				.rst          (rst),
				.upd          (sample_upd),
				.var_mode     (var_mode),
				.v            (v_ph[g]),
				.i            (i_ph[g]),
				.i_q          (iq_ph[g]),
				.v_rms        (vr_ph[g]),
				.i_rms        (ir_ph[g]),
				.active_pwr   (active_pwr[g]),
				.reactive_pwr (reactive_pwr[g]),
				.apparent_pwr (apparent_pwr[g]),
				.active_nrg   (active_nrg[g]),
				.reactive_nrg (reactive_nrg[g]),
				.apparent_nrg (apparent_nrg[g])
			);
		end
	endgenerate

	// ************************************************************
	// Sag status
	// ************************************************************
	// The detector watches the raw phase samples in every topology, so a
	// three-wire meter still reports dips seen on its phase B input.
	// sag behaviour select
	eais_sag_detect u_sag
	(
		.clk       (clk),
		.rst       (rst),
		.upd       (sample_upd),
		.rise_mode (cfg_reg[eais_pkg::SAG_MODE_BIT]),
		.clr       (sag_clr),
		.level     (level_reg),
		.v_ph      (vs_ph),
		.sag_flag  (sag_flag)
	);

	assign sag_flag_out = sag_flag;

	// ************************************************************
	// Checks
	// ************************************************************
	logic signed [eais_pkg::POWER_W-1:0] chk_delta_p;
	assign chk_delta_p = (-va_ext) * ib_smp;
	logic signed [eais_pkg::POWER_W-1:0] chk_wye_p;
	assign chk_wye_p = vb_smp * ib_smp;

	default clocking cb_main @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_wire3_update;
		sample_upd && topo == eais_pkg::TOPO_3W_DELTA;
	endsequence

	a_b_zero_3w: assert property (s_wire3_update |=> active_pwr[1] == '0
		&& reactive_pwr[1] == '0 && apparent_pwr[1] == '0)
		else $error("phase B power not zero in three-wire");
	a_b_line_volt: assert property (s_wire3_update ##1 topo == eais_pkg::TOPO_3W_DELTA
		|-> ib_filt_out == '0 && line_vac_smp == $past(va_ext) - $past(vc_ext))
		else $error("three-wire substitution wrong");
	a_phase_b_voltage_rms_line: assert property (topo == eais_pkg::TOPO_3W_DELTA |=>
		phase_b_voltage_rms_reg == $past(vac_rms))
		else $error("phase B rms not the line rms");
	a_delta_neg_va: assert property (sample_upd && topo == eais_pkg::TOPO_4W_DELTA |=>
		active_pwr[1] == $past(chk_delta_p))
		else $error("four-wire delta phase B power wrong");
	a_wye_direct: assert property (sample_upd && topo == eais_pkg::TOPO_4W_WYE
		|=> active_pwr[1] == $past(chk_wye_p))
		else $error("wye topology does not use phase B voltage");
	a_rsv_stays: assert property (cfg_reg[7])
		else $error("reserved bit lost its value");
	a_rsv_read: assert property (rd_fire
		&& reg_hit(wb_adr_i, eais_pkg::OFS_ACCUM_MODE_CFG) |=> wb_dat_o[7])
		else $error("reserved bit reads zero");
	a_phase_b_voltage_rms_wye: assert property (topo == eais_pkg::TOPO_4W_WYE |=>
		phase_b_voltage_rms_reg == $past(vb_rms))
		else $error("phase B rms not the phase B input");
	a_delta_rms: assert property (topo == eais_pkg::TOPO_4W_DELTA |=>
		phase_b_voltage_rms_reg == $past(va_rms))
		else $error("four-wire delta phase B rms wrong");
	a_delta_ibf: assert property (topo == eais_pkg::TOPO_4W_DELTA |=>
		ib_filt_out == $past(ib_smp))
		else $error("four-wire delta phase B current altered");
	a_level_write: assert property (wr_fire && wb_sel_i[1:0] == 2'h3
		&& reg_hit(wb_adr_i, eais_pkg::OFS_SAG_LEVEL)
		|=> level_reg == $past(wb_dat_i[15:0]))
		else $error("sag threshold write not applied");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	a_ack_timely: assert property (bus_req && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not answered");
	a_cfg_apply: assert property (wr_fire && wb_sel_i[0]
		&& reg_hit(wb_adr_i, eais_pkg::OFS_ACCUM_MODE_CFG)
		|=> var_mode == $past(wb_dat_i[3:2]) && topo == $past(wb_dat_i[5:4]))
		else $error("configuration write not applied");

endmodule : eais_energy_accum_input_select

/* File: tb/test_energy_accum_input_select.sv */
module test_energy_accum_input_select;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct
	{
		logic [2:0][32:0] ap;
		logic [2:0][32:0] rp;
		logic [2:0][31:0] sp;
		logic [2:0][47:0] an;
		logic [2:0][47:0] rn;
		logic [2:0][47:0] sn;
		logic [16:0]      vac;
		logic [15:0]      ibf;
	} eais_exp_s;

	logic                     clk;
	logic                     rst;
	logic                     wb_cyc;
	logic                     wb_stb;
	logic                     wb_we;
	logic [7:0]               wb_adr;
	logic [31:0]              wb_dat;
	logic [31:0]              wb_dat_o;
	logic                     wb_ack_o;
	logic                     sample_upd;
	logic signed [15:0]       v_s [3];
	logic signed [15:0]       i_s [3];
	logic signed [15:0]       q_s [3];
	logic [15:0]              vr [3];
	logic [15:0]              ir [3];
	logic [15:0]              vac_r;
	logic [16:0]              line_vac;
	logic [15:0]              ib_filt;
	logic [2:0][32:0]         act_p;
	logic [2:0][32:0]         rea_p;
	logic [2:0][31:0]         app_p;
	logic [2:0][47:0]         act_n;
	logic [2:0][47:0]         rea_n;
	logic [2:0][47:0]         app_n;
	logic                     sag_out;
	logic [2:0][47:0]         m_an;
	logic [2:0][47:0]         m_rn;
	logic [2:0][47:0]         m_sn;
	logic [1:0]               topo_c;
	logic [1:0]               var_c;
	logic signed [15:0]       vov [3];
	bit                       use_vov;
	bit                       upd_seen;
	int                       errors;
	int                       checks_done;
	eais_exp_s                exp_q[$];
	eais_exp_s                ex_m;
	logic [31:0]              rd_q[$];

	eais_energy_accum_input_select DUT
	(
		.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF),
		.wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.sample_upd(sample_upd), .va_smp(v_s[0]), .vb_smp(v_s[1]),
		.vc_smp(v_s[2]), .ia_smp(i_s[0]), .ib_smp(i_s[1]),
		.ic_smp(i_s[2]), .ia_q_smp(q_s[0]), .ib_q_smp(q_s[1]),
		.ic_q_smp(q_s[2]), .va_rms(vr[0]), .vb_rms(vr[1]),
		.vc_rms(vr[2]), .vac_rms(vac_r), .ia_rms(ir[0]),
		.ib_rms(ir[1]), .ic_rms(ir[2]), .line_vac_smp(line_vac),
		.ib_filt_out(ib_filt), .active_pwr(act_p), .reactive_pwr(rea_p),
		.apparent_pwr(app_p), .active_nrg(act_n), .reactive_nrg(rea_n),
		.apparent_nrg(app_n), .sag_flag_out(sag_out)
	);

	always #5 clk = ~clk;

	// ************************************************************
	// Checking
	// ************************************************************
	task automatic cmp_val(input logic [47:0] got, input logic [47:0] exp,
		input string what);
		checks_done++;
		if (got !== exp)
		begin
			errors++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : cmp_val

	task automatic report_and_stop();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : report_and_stop

	// Read results are compared at the ack edge, while the request stands.
	always @(posedge clk)
	begin
		if (wb_ack_o === 1'b1 && wb_we === 1'b0)
		begin
			if (rd_q.size() == 0)
				cmp_val(48'h0, 48'h1, "unexpected read");
			else
				cmp_val(wb_dat_o, rd_q.pop_front(), "read");
		end
	end

	always @(posedge clk)
	begin
		if (upd_seen)
		begin
			ex_m = exp_q.pop_front();
			cmp_val(line_vac, ex_m.vac, "line vac");
			cmp_val(ib_filt, ex_m.ibf, "ib filt");
			for (int k = 0; k < 3; k++)
			begin
				cmp_val(act_p[k], ex_m.ap[k], "act pwr");
				cmp_val(rea_p[k], ex_m.rp[k], "rea pwr");
				cmp_val(app_p[k], ex_m.sp[k], "app pwr");
				cmp_val(act_n[k], ex_m.an[k], "act nrg");
				cmp_val(rea_n[k], ex_m.rn[k], "rea nrg");
				cmp_val(app_n[k], ex_m.sn[k], "app nrg");
			end
		end
		upd_seen <= sample_upd;
	end

	// ************************************************************
	// Drivers
	// ************************************************************
	task automatic wb_xfer(input logic we, input logic [7:0] adr,
		input logic [31:0] d);
		int n;
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we  <= we;
		wb_adr <= adr;
		wb_dat <= d;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (wb_ack_o !== 1'b1 && n < 20);
		if (wb_ack_o !== 1'b1)
		begin
			errors++;
			report_and_stop();
		end
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		@(posedge clk);
	endtask : wb_xfer

	task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
		rd_q.push_back(exp);
		wb_xfer(1'b0, adr, 32'h0000_0000);
	endtask : rd

	// One update edge with random samples; the model mirrors the topology.
	task automatic upd_once();
		eais_exp_s          e;
		logic signed [15:0] a [3];
		logic signed [15:0] b [3];
		logic signed [15:0] c [3];
		logic [15:0]        r1 [3];
		logic [15:0]        r2 [3];
		logic [15:0]        x;
		logic signed [16:0] ve;
		logic signed [15:0] ie;
		logic signed [15:0] qe;
		logic [15:0]        vre;
		logic [15:0]        ire;
		logic signed [32:0] p;
		logic signed [32:0] q;
		x = 16'($urandom);
		for (int k = 0; k < 3; k++)
		begin
			a[k] = use_vov ? vov[k] : 16'($urandom);
			b[k] = 16'($urandom);
			c[k] = 16'($urandom);
			r1[k] = 16'($urandom);
			r2[k] = 16'($urandom);
		end
		for (int k = 0; k < 3; k++)
		begin
			ve = a[k];
			ie = b[k];
			qe = c[k];
			vre = r1[k];
			ire = r2[k];
			if (k == 1 && topo_c == 2'h1)
			begin
				ve = a[0] - a[2];
				ie = 16'h0000;
				qe = 16'h0000;
				ire = 16'h0000;
				vre = x;
			end
			if (k == 1 && topo_c == 2'h3)
			begin
				ve = -a[0];
				vre = r1[0];
			end
			p = ve * ie;
			q = ve * qe;
			if ((var_c == 2'h2 && p < 0) || (var_c == 2'h3 && q < 0))
				q = -q;
			e.ap[k] = p;
			e.rp[k] = q;
			e.sp[k] = vre * ire;
			m_an[k] = m_an[k] + 48'(p);
			m_rn[k] = m_rn[k] + 48'(q);
			m_sn[k] = m_sn[k] + 48'(e.sp[k]);
			v_s[k] <= a[k];
			i_s[k] <= b[k];
			q_s[k] <= c[k];
			vr[k] <= r1[k];
			ir[k] <= r2[k];
		end
		e.an = m_an;
		e.rn = m_rn;
		e.sn = m_sn;
		e.vac = a[0] - a[2];
		e.ibf = (topo_c == 2'h1) ? 16'h0000 : b[1];
		vac_r <= x;
		sample_upd <= 1'b1;
		exp_q.push_back(e);
		@(posedge clk);
	endtask : upd_once

	task automatic sag_step(input logic [15:0] vb, input logic [31:0] exp);
		vov[1] = vb;
		upd_once();
		sample_upd <= 1'b0;
		rd(8'h08, exp);
		cmp_val(sag_out, exp[0], "sag pin");
	endtask : sag_step

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial
	begin
		clk = 1'b0;
		rst = 1'b1;
		{wb_cyc, wb_stb, wb_we, sample_upd} = 4'h0;
		wb_adr = 8'h00;
		wb_dat = 32'h0000_0000;
		for (int k = 0; k < 3; k++)
		begin
			{v_s[k], i_s[k], q_s[k], vr[k], ir[k]} = 80'h0;
			vov[k] = 16'h2000;
		end
		vac_r = 16'h0000;
		{m_an, m_rn, m_sn} = '0;
		{topo_c, var_c} = 4'h0;
		void'($urandom(86));
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(8'h00, 32'h0000_0080);
		rd(8'h10, 32'h0000_0000);
		for (int t = 0; t < 4; t++)
		begin
			for (int v = 0; v < 4; v++)
			begin
				topo_c = 2'(t);
				var_c = 2'(v);
				wb_xfer(1'b1, 8'h00, {26'h0, topo_c, var_c, 2'h1});
				rd(8'h00, {24'h0, 2'h2, topo_c, var_c, 2'h1});
				upd_once();
				upd_once();
				sample_upd <= 1'b0;
				@(posedge clk);
				rd(8'h0C, {16'h0, (t == 1) ? vac_r :
					(t == 3) ? vr[0] : vr[1]});
			end
		end
		use_vov = 1'b1;
		topo_c = 2'h0;
		var_c = 2'h0;
		wb_xfer(1'b1, 8'h04, 32'h0000_1000);
		wb_xfer(1'b1, 8'h00, 32'h0000_0000);
		sag_step(16'hF800, 32'h0000_0001);
		wb_xfer(1'b1, 8'h08, 32'h0000_0001);
		rd(8'h08, 32'h0000_0000);
		wb_xfer(1'b1, 8'h00, 32'h0000_0040);
		rd(8'h00, 32'h0000_00C0);
		sag_step(16'h0100, 32'h0000_0000);
		sag_step(16'h2000, 32'h0000_0001);
		repeat (3) @(posedge clk);
		cmp_val(48'(rd_q.size() + exp_q.size()), 48'h0, "left over");
		report_and_stop();
	end

	initial
	begin
		repeat (20000) @(posedge clk);
		errors++;
		report_and_stop();
	end

endmodule : test_energy_accum_input_select
